// File: logic/gstmr_top.sv
// Three gated sixteen-bit timers with register port, prescalers and gate logic
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module gstmr_top (
    input  wire logic                            CLK_SYS,
    input  wire logic                            RSTN,
    input  wire logic                            CE,
    input  wire logic [gstmr_pkg::ADDR_W-1:0]    ADDR,
    input  wire logic [gstmr_pkg::DATA_W-1:0]    WDATA,
    input  wire logic                            WR,
    input  wire logic                            RD,
    output var  logic [gstmr_pkg::DATA_W-1:0]    RDATA,
    input  wire logic                            SLEEP,
    input  wire logic [gstmr_pkg::NCH-1:0]       EXT_COUNT_IN,
    input  wire logic [gstmr_pkg::NCH-1:0]       GATE_IN,
    input  wire logic [gstmr_pkg::NCH-1:0]       CRYSTAL_IN,
    output var  logic [gstmr_pkg::NCH-1:0]       CRYSTAL_OUT,
    input  wire logic                            TMR0_OVF,
    input  wire logic                            CMP1_OUT,
    input  wire logic                            CMP2_OUT,
    output var  logic [gstmr_pkg::NCH-1:0]       OVF_IRQ
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic logic reg_hit(
        input logic [gstmr_pkg::ADDR_W-1:0] a,
        input int unsigned                  ch,
        input logic [1:0]                   ofs
    );
        reg_hit = (a[3:2] == 2'(ch)) && (a[1:0] == ofs);
    endfunction : reg_hit

    function automatic logic psc_hit(
        input logic [2:0] p,
        input logic [1:0] sel
    );
        logic [2:0] m;
        m = 3'h0;
        case (sel)
            2'h0: m = 3'h0;
            2'h1: m = 3'h1;
            2'h2: m = 3'h3;
            2'h3: m = 3'h7;
            default: m = 3'h0;
        endcase
        psc_hit = (p & m) == m;
    endfunction : psc_hit

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and input synchronizers

    logic                        rst_n;
    logic [gstmr_pkg::NCH-1:0]   ext_s;
    logic [gstmr_pkg::NCH-1:0]   gate_s;
    logic [gstmr_pkg::NCH-1:0]   xtal_s;
    logic [1:0]                  cmp_s;
    logic                        instr_tick;
    logic                        lf_tick;

    gstmr_sync #(
        .W (1)
    ) u_rst_sync (
        .clk   (CLK_SYS),
        .rst_n (RSTN),
        .en    (CE),
        .d     (1'b1),
        .q     (rst_n)
    );

    gstmr_sync #(
        .W (3 * gstmr_pkg::NCH + 2)
    ) u_pin_sync (
        .clk   (CLK_SYS),
        .rst_n (rst_n),
        .en    (CE),
        .d     ({EXT_COUNT_IN, GATE_IN, CRYSTAL_IN, CMP2_OUT, CMP1_OUT}),
        .q     ({ext_s, gate_s, xtal_s, cmp_s})
    );

    ////////////////////////////////////////////////////////////////////////////
    // Shared time bases; both stop while the processor sleeps

    gstmr_tick #(
        .DIV (gstmr_pkg::INSTR_DIV)
    ) u_instr_tick (
        .clk   (CLK_SYS),
        .rst_n (rst_n),
        .en    (CE),
        .run   (!SLEEP),
        .tick  (instr_tick)
    );

    gstmr_tick #(
        .DIV (gstmr_pkg::LFOSC_DIV)
    ) u_lf_tick (
        .clk   (CLK_SYS),
        .rst_n (rst_n),
        .en    (CE),
        .run   (!SLEEP),
        .tick  (lf_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Timer state

    gstmr_pkg::gstmr_state_t st_q;
    gstmr_pkg::gstmr_state_t st_d;

    always_comb begin
        logic        on;
        logic        async_m;
        logic        oscen;
        logic [1:0]  cs;
        logic [1:0]  ps;
        logic [1:0]  gsrc;
        logic        gate_lvl;
        logic        gate_ok;
        logic        run;
        logic        awake;
        logic        src_lvl;
        logic        rise;
        logic        fall;
        logic        edge_ok;
        logic        tick;
        logic        wr_lo;
        logic        wr_hi;
        logic        wr_tc;
        logic        wr_gc;
        logic        ovf_set;
        logic [7:0]  rd_val;
        on       = 1'b0;
        async_m  = 1'b0;
        oscen    = 1'b0;
        cs       = 2'h0;
        ps       = 2'h0;
        gsrc     = 2'h0;
        gate_lvl = 1'b0;
        gate_ok  = 1'b0;
        run      = 1'b0;
        awake    = 1'b0;
        src_lvl  = 1'b0;
        rise     = 1'b0;
        fall     = 1'b0;
        edge_ok  = 1'b0;
        tick     = 1'b0;
        wr_lo    = 1'b0;
        wr_hi    = 1'b0;
        wr_tc    = 1'b0;
        wr_gc    = 1'b0;
        ovf_set  = 1'b0;
        rd_val   = gstmr_pkg::RDATA_RST;
        st_d     = st_q;

        for (int unsigned i = 0; i < gstmr_pkg::NCH; i++) begin // RULE18
            on      = st_q.tcon[i][gstmr_pkg::TC_ON];
            async_m = st_q.tcon[i][gstmr_pkg::TC_ASYNC];
            oscen   = st_q.tcon[i][gstmr_pkg::TC_OSCEN];
            cs      = st_q.tcon[i][gstmr_pkg::TC_CS_LO +: 2];
            ps      = st_q.tcon[i][gstmr_pkg::TC_PS_LO +: 2];
            gsrc    = st_q.gcon[i][gstmr_pkg::GC_SRC_LO +: 2];

            wr_lo = WR && reg_hit(ADDR, i, gstmr_pkg::OFS_CNT_LO);
            wr_hi = WR && reg_hit(ADDR, i, gstmr_pkg::OFS_CNT_HI);
            wr_tc = WR && reg_hit(ADDR, i, gstmr_pkg::OFS_TCON);
            wr_gc = WR && reg_hit(ADDR, i, gstmr_pkg::OFS_GCON);

            // Gate source selection
            case (gsrc) // RULE21
                gstmr_pkg::GS_PIN:   gate_lvl = gate_s[i];
                gstmr_pkg::GS_T0OVF: gate_lvl = TMR0_OVF;
                gstmr_pkg::GS_CMP1:  gate_lvl = cmp_s[0];
                gstmr_pkg::GS_CMP2:  gate_lvl = cmp_s[1];
                default:             gate_lvl = gate_s[i];
            endcase

            // Gate opens when its level matches the polarity bit
            gate_ok = !st_q.gcon[i][gstmr_pkg::GC_GE] // RULE15
                      || (gate_lvl == st_q.gcon[i][gstmr_pkg::GC_POL]); // RULE17
            run     = on && gate_ok; // RULE2

            // Only the asynchronous external path survives sleep
            awake = !SLEEP || (cs == gstmr_pkg::CS_EXT && async_m); // RULE11

            // External level: crystal when the oscillator is on, else the pin
            src_lvl = oscen ? xtal_s[i] : ext_s[i];
            rise    = src_lvl && !st_q.src_prev[i]; // RULE5
            fall    = !src_lvl && st_q.src_prev[i];
            st_d.src_prev[i] = src_lvl;

            // Falling edge must arm the counter first
            if (!on || wr_lo || wr_hi) begin
                st_d.armed[i] = 1'b0; // RULE6
            end else if (fall) begin
                st_d.armed[i] = 1'b1; // RULE6
            end
            edge_ok = rise && st_q.armed[i]; // RULE6

            // Synchronous mode waits for the next instruction phase
            if (async_m || !on) begin
                st_d.pend[i] = 1'b0; // RULE10
            end else if (edge_ok) begin
                st_d.pend[i] = 1'b1; // RULE14
            end else if (instr_tick) begin
                st_d.pend[i] = 1'b0;
            end

            case (cs) // RULE3
                gstmr_pkg::CS_LFOSC: tick = lf_tick;
                gstmr_pkg::CS_EXT:   tick = async_m ? edge_ok // RULE10
                                                    : (st_q.pend[i] && instr_tick);
                gstmr_pkg::CS_SYS:   tick = 1'b1; // RULE4
                gstmr_pkg::CS_INSTR: tick = instr_tick;
                default:             tick = 1'b0;
            endcase

            // Prescaler and counter; a write wins over an increment
            ovf_set = 1'b0;
            if (wr_lo || wr_hi) begin
                st_d.psc[i] = gstmr_pkg::PSC_RST; // RULE8
                if (wr_lo) begin
                    st_d.cnt[i][7:0] = WDATA; // RULE1
                end
                if (wr_hi) begin
                    st_d.cnt[i][15:8] = WDATA; // RULE1
                end
            end else if (run && awake && tick) begin // RULE16
                st_d.psc[i] = st_q.psc[i] + 3'h1; // RULE7
                if (psc_hit(st_q.psc[i], ps)) begin // RULE7
                    st_d.psc[i] = gstmr_pkg::PSC_RST;
                    st_d.cnt[i] = st_q.cnt[i] + 16'h0001; // RULE1
                    ovf_set     = (st_q.cnt[i] == gstmr_pkg::CNT_MAX); // RULE20
                end
            end

            // Control registers
            if (wr_tc) begin
                st_d.tcon[i] = WDATA & gstmr_pkg::TC_MASK;
            end
            if (wr_gc) begin
                st_d.gcon[i] = WDATA & gstmr_pkg::GC_MASK;
            end

            // Overflow flag: hardware set wins over a software clear
            if (ovf_set) begin
                st_d.ovf[i] = 1'b1; // RULE20
            end else if (wr_gc) begin
                st_d.ovf[i] = WDATA[gstmr_pkg::GC_OVF]; // RULE20
            end

            // Crystal amplifier runs regardless of sleep
            st_d.xtal_out[i] = oscen && !xtal_s[i]; // RULE9

            // Read mux; the count lives in this domain so reads are coherent
            if (reg_hit(ADDR, i, gstmr_pkg::OFS_CNT_LO)) begin
                rd_val = st_q.cnt[i][7:0]; // RULE12
            end else if (reg_hit(ADDR, i, gstmr_pkg::OFS_CNT_HI)) begin
                rd_val = st_q.cnt[i][15:8]; // RULE12
            end else if (reg_hit(ADDR, i, gstmr_pkg::OFS_TCON)) begin
                rd_val = st_q.tcon[i];
            end else if (reg_hit(ADDR, i, gstmr_pkg::OFS_GCON)) begin
                rd_val = st_q.gcon[i];
                rd_val[gstmr_pkg::GC_OVF] = st_q.ovf[i];
            end
        end

        // Read data stand only in the cycle after the strobe
        st_d.rdata = RD ? rd_val : gstmr_pkg::RDATA_RST;

        if (!CE) begin
            st_d = st_q;
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            for (int unsigned i = 0; i < gstmr_pkg::NCH; i++) begin
                st_q.cnt[i]  <= gstmr_pkg::CNT_RST;
                st_q.tcon[i] <= gstmr_pkg::TCON_RST;
                st_q.gcon[i] <= gstmr_pkg::GCON_RST;
                st_q.psc[i]  <= gstmr_pkg::PSC_RST;
            end
            st_q.armed    <= '0;
            st_q.src_prev <= '0;
            st_q.pend     <= '0;
            st_q.ovf      <= '0;
            st_q.xtal_out <= '0;
            st_q.rdata    <= gstmr_pkg::RDATA_RST;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from flops

    assign RDATA       = st_q.rdata;
    assign OVF_IRQ     = st_q.ovf; // RULE11
    assign CRYSTAL_OUT = st_q.xtal_out;

endmodule : gstmr_top
`default_nettype wire

// File: logic/gstmr_pkg.sv
// Constants, register map and state types of the gated sixteen-bit timer
//
// Overview of operation
// RULE1: Sixteen-bit up-counter written and read as high and low bytes, writes take effect at once.
// RULE2: On-bit clear means off; on alone counts always; on with gate-enable follows gate.
// RULE3: Clock select 11 low-freq osc, 10 external pin, 01 system clock, 00 instruction clock.
// RULE4: System clock source advances four counts per instruction cycle.
// RULE5: External source counts rising edges, synchronized or asynchronous.
// RULE6: External mode needs a falling edge before first rising edge after enable, write, disable.
// RULE7: Prescaler divides by 1, 2, 4 or 8 and is hidden from software.
// RULE8: Writing either count byte clears the prescaler.
// RULE9: Oscillator-enable starts the crystal oscillator, which keeps running in sleep.
// RULE10: Sync-disable bit lets the external input count free of instruction phases.
// RULE11: Asynchronous external counting runs in sleep and its overflow requests wake-up.
// RULE12: Reading count bytes during asynchronous counting returns a valid value.
// RULE13: Software stops the counter before writing; a racing write may corrupt the count.
// RULE14: Switching sync mode may lose or add one increment.
// RULE15: Gate-enable bit turns gating on; polarity bit picks the counting gate level.
// RULE16: Gate open counts on selected clock edge; gate closed holds the count.
// RULE17: Counting happens when gate level equals the polarity bit.
// RULE18: Three identical timers, each with own counter, control and gate.
// RULE19: Software may preload FC00h so overflow marks 1024 oscillator cycles.
// RULE20: Count wraps FFFFh to 0000h and sets a flag only software clears.
// RULE21: Gate source 00 gate pin, 01 eight-bit timer overflow, 10/11 comparators.
package gstmr_pkg;
    localparam int unsigned NCH        = 3;
    localparam int unsigned ADDR_W     = 4;
    localparam int unsigned DATA_W     = 8;
    localparam logic [1:0]  OFS_CNT_LO = 2'h0;
    localparam logic [1:0]  OFS_CNT_HI = 2'h1;
    localparam logic [1:0]  OFS_TCON   = 2'h2;
    localparam logic [1:0]  OFS_GCON   = 2'h3;
    // Timer control register fields
    localparam int unsigned TC_ON      = 0;
    localparam int unsigned TC_ASYNC   = 1;
    localparam int unsigned TC_OSCEN   = 2;
    localparam int unsigned TC_PS_LO   = 4;
    localparam int unsigned TC_CS_LO   = 6;
    localparam logic [7:0]  TC_MASK    = 8'hf7;
    // Gate control register fields
    localparam int unsigned GC_SRC_LO  = 0;
    localparam int unsigned GC_OVF     = 3;
    localparam int unsigned GC_POL     = 6;
    localparam int unsigned GC_GE      = 7;
    localparam logic [7:0]  GC_MASK    = 8'hc3;
    // Clock select and gate source codes
    localparam logic [1:0]  CS_INSTR   = 2'h0;
    localparam logic [1:0]  CS_SYS     = 2'h1;
    localparam logic [1:0]  CS_EXT     = 2'h2;
    localparam logic [1:0]  CS_LFOSC   = 2'h3;
    localparam logic [1:0]  GS_PIN     = 2'h0;
    localparam logic [1:0]  GS_T0OVF   = 2'h1;
    localparam logic [1:0]  GS_CMP1    = 2'h2;
    localparam logic [1:0]  GS_CMP2    = 2'h3;
    // Values after reset and the count's top value
    localparam logic [15:0] CNT_RST    = 16'h0000;
    localparam logic [7:0]  TCON_RST   = 8'h00;
    localparam logic [7:0]  GCON_RST   = 8'h00;
    localparam logic [2:0]  PSC_RST    = 3'h0;
    localparam logic [7:0]  RDATA_RST  = 8'h00;
    localparam logic [15:0] CNT_MAX    = 16'hffff;
    // Cycle counts of the internal time bases
    localparam int unsigned INSTR_DIV  = 4;
    localparam int unsigned LFOSC_DIV  = 640;

    typedef struct packed {
        logic [NCH-1:0][15:0] cnt;
        logic [NCH-1:0][7:0]  tcon;
        logic [NCH-1:0][7:0]  gcon;
        logic [NCH-1:0][2:0]  psc;
        logic [NCH-1:0]       armed;
        logic [NCH-1:0]       src_prev;
        logic [NCH-1:0]       pend;
        logic [NCH-1:0]       ovf;
        logic [NCH-1:0]       xtal_out;
        logic [7:0]           rdata;
    } gstmr_state_t;
endpackage : gstmr_pkg

// File: logic/gstmr_sync.sv
// Two-flop synchronizer for levels from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module gstmr_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         en,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } gstmr_sync_t;

    gstmr_sync_t st_q;
    gstmr_sync_t st_d;

    always_comb begin
        st_d = st_q;
        if (en) begin
            st_d.s1 = d;
            st_d.s2 = st_q.s1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign q = st_q.s2;
endmodule : gstmr_sync
`default_nettype wire

// File: logic/gstmr_tick.sv
// Free-running divider giving a one-cycle tick every DIV enabled cycles
`timescale 1ns/100ps
`default_nettype none
module gstmr_tick #(
    parameter int unsigned DIV = 4
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic en,
    input  wire logic run,
    output var  logic tick
);
    localparam logic [15:0] LAST = 16'(DIV - 1);

    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } gstmr_tick_t;

    gstmr_tick_t st_q;
    gstmr_tick_t st_d;

    always_comb begin
        st_d = st_q;
        if (en) begin
            st_d.tick = 1'b0;
            if (run) begin
                if (st_q.cnt == LAST) begin
                    st_d.cnt  = 16'h0000;
                    st_d.tick = 1'b1;
                end else begin
                    st_d.cnt = st_q.cnt + 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tick = st_q.tick;
endmodule : gstmr_tick
`default_nettype wire

// File: bench/gstmr_ext_src.sv
// Pulse source standing in for an external count clock or crystal
`timescale 1ns/100ps
`default_nettype none
module gstmr_ext_src #(
    parameter int HALF = 6
) (
    input  wire logic clk,
    input  wire logic run,
    output var  logic pin
);
    int cnt;
    initial begin
        pin = 1'b1;
        cnt = 0;
    end
    // Idles high, so every burst opens with a falling edge
    always @(posedge clk) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1) pin <= run ? ~pin : 1'b1;
    end
endmodule : gstmr_ext_src
`default_nettype wire

// File: bench/gstmr_props.sv
// Assertion checker on the timer register port and overflow flags
`timescale 1ns/100ps
`default_nettype none
module gstmr_props (
    input wire logic       CLK_SYS,
    input wire logic       RSTN,
    input wire logic       CE,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    input wire logic [2:0] OVF_IRQ,
    input wire logic [2:0] CRYSTAL_OUT
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    wire logic [1:0] ch = ADDR[3:2];
    wire logic [1:0] rg = ADDR[1:0];
    wire logic       gw = CE && WR && ADDR == {2'h0, gstmr_pkg::OFS_GCON};
    ////////////////////////////////////////////////////////////////////////////
    property p_rd_idle; $past(CE) && !$past(RD) |-> RDATA == 8'h00; endproperty
    property p_unmapped; CE && RD && ch == 2'h3 |=> RDATA == 8'h00; endproperty
    property p_tcon_rsv; CE && RD && rg == gstmr_pkg::OFS_TCON |=> !RDATA[3]; endproperty
    property p_gcon_rsv;
        CE && RD && rg == gstmr_pkg::OFS_GCON |=> RDATA[5:4] == 2'h0 && !RDATA[2];
    endproperty
    property p_cnt_rb;
        CE && WR && rg == gstmr_pkg::OFS_CNT_LO && ch != 2'h3 ##1 CE && RD && ADDR == $past(ADDR)
        |=> RDATA == $past(WDATA, 2);
    endproperty
    property p_tcon_rb;
        CE && WR && rg == gstmr_pkg::OFS_TCON && ch != 2'h3 ##1 CE && RD && ADDR == $past(ADDR)
        |=> RDATA == ($past(WDATA, 2) & gstmr_pkg::TC_MASK);
    endproperty
    property p_ovf_hold; CE && OVF_IRQ[0] && !gw |=> OVF_IRQ[0]; endproperty
    property p_ovf_set; gw && WDATA[gstmr_pkg::GC_OVF] |=> OVF_IRQ[0]; endproperty
    property p_ovf_rd;
        CE && RD && ch != 2'h3 && rg == gstmr_pkg::OFS_GCON
        |=> RDATA[gstmr_pkg::GC_OVF] == $past(OVF_IRQ[ch]);
    endproperty
    property p_rst_out;
        $rose(RSTN) |-> OVF_IRQ == 3'h0 && RDATA == 8'h00 && CRYSTAL_OUT == 3'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_tcon_rsv: assert property (p_tcon_rsv) else $error("control bit 3 set");
    a_gcon_rsv: assert property (p_gcon_rsv) else $error("gate reserved bits set");
    a_cnt_rb: assert property (p_cnt_rb) else $error("count byte write lost");
    a_tcon_rb: assert property (p_tcon_rb) else $error("control readback wrong");
    a_ovf_hold: assert property (p_ovf_hold) else $error("flag cleared by itself");
    a_ovf_set: assert property (p_ovf_set) else $error("flag write lost");
    a_ovf_rd: assert property (p_ovf_rd) else $error("flag readback wrong");
    a_rst_out: assert property (p_rst_out) else $error("outputs not reset");
    c_ovf: cover property ($rose(OVF_IRQ[2]));
    c_unmapped: cover property (RD && ch == 2'h3);
    c_tcon_wr: cover property (WR && rg == gstmr_pkg::OFS_TCON);
endmodule : gstmr_props
bind gstmr_top gstmr_props u_props (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .CE(CE), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .OVF_IRQ(OVF_IRQ),
    .CRYSTAL_OUT(CRYSTAL_OUT));
`default_nettype wire

// File: bench/gstmr_tb.sv
// Self-checking bench for the gated sixteen-bit timer
`timescale 1ns/100ps
`default_nettype none
module gstmr_tb;
    typedef struct {logic [3:0] a; logic [7:0] d; logic [7:0] e;} gstmr_row_t;
    logic       CLK_SYS, RSTN, CE, WR, RD, SLEEP, TMR0_OVF, CMP1_OUT, CMP2_OUT;
    logic [3:0] ADDR;
    logic [7:0] WDATA, RDATA, rd_v, keep;
    logic [2:0] GATE_IN, CRYSTAL_OUT, OVF_IRQ, ext_run, xtal_run;
    wire logic [2:0] EXT_COUNT_IN, CRYSTAL_IN;
    logic [1:0] c;
    int         failures, checks, rises, xo, i, m, p, s, g;
    gstmr_row_t rows [0:16] = '{'{4'h2, 8'hfe, 8'hf6}, '{4'h6, 8'hfe, 8'hf6},
        '{4'ha, 8'hfe, 8'hf6}, '{4'h2, 8'h00, 8'h00}, '{4'h6, 8'h00, 8'h00},
        '{4'ha, 8'h00, 8'h00}, '{4'h3, 8'hcb, 8'hcb}, '{4'h3, 8'h00, 8'h00},
        '{4'h7, 8'hc1, 8'hc1}, '{4'hb, 8'h42, 8'h42}, '{4'h7, 8'h00, 8'h00},
        '{4'hb, 8'h00, 8'h00}, '{4'h0, 8'h34, 8'h34}, '{4'h1, 8'hab, 8'hab},
        '{4'h9, 8'h5a, 8'h5a}, '{4'hc, 8'hff, 8'h00}, '{4'hf, 8'hff, 8'h00}};

    gstmr_top u_dut (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .CE(CE), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .SLEEP(SLEEP), .EXT_COUNT_IN(EXT_COUNT_IN),
        .GATE_IN(GATE_IN), .CRYSTAL_IN(CRYSTAL_IN), .CRYSTAL_OUT(CRYSTAL_OUT),
        .TMR0_OVF(TMR0_OVF), .CMP1_OUT(CMP1_OUT), .CMP2_OUT(CMP2_OUT), .OVF_IRQ(OVF_IRQ));
    gstmr_ext_src u_ext [2:0] (.clk(CLK_SYS), .run(ext_run), .pin(EXT_COUNT_IN));
    gstmr_ext_src u_xtal [2:0] (.clk(CLK_SYS), .run(xtal_run), .pin(CRYSTAL_IN));
    always @(posedge EXT_COUNT_IN[1] or posedge CRYSTAL_IN[2]) rises++;
    always @(posedge CRYSTAL_OUT[2]) xo++;

    initial begin
        CLK_SYS = 1'b0;
        forever #25 CLK_SYS = ~CLK_SYS;
    end
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [3:0] ad(input logic [1:0] ch, input logic [1:0] o);
        return {ch, o};
    endfunction : ad
    task automatic stop_test;
        if (failures == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : stop_test
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input int tol);
        logic ok;
        ok = 1'b0;
        for (int k = -tol; k <= tol; k++) if (got === 16'(int'(exp) + k)) ok = 1'b1;
        checks++;
        if (!ok) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // Write, optionally followed at once by a read of the same place
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic rb);
        @(posedge CLK_SYS);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK_SYS);
        WR <= 1'b0;
        RD <= rb;
        if (rb) begin
            @(posedge CLK_SYS);
            RD <= 1'b0;
            #1 rd_v = RDATA;
        end
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge CLK_SYS);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK_SYS);
        RD <= 1'b0;
        #1 rd_v = RDATA;
    endtask : rd
    task automatic runcnt(input logic [1:0] ch, input logic [7:0] tc, input int n);
        wr(ad(ch, gstmr_pkg::OFS_CNT_LO), 8'h00, 1'b0);
        wr(ad(ch, gstmr_pkg::OFS_CNT_HI), 8'h00, 1'b0);
        wr(ad(ch, gstmr_pkg::OFS_TCON), tc, 1'b0);
        repeat (n) @(posedge CLK_SYS);
        wr(ad(ch, gstmr_pkg::OFS_TCON), 8'h00, 1'b0);
        rd(ad(ch, gstmr_pkg::OFS_CNT_LO));
    endtask : runcnt
    initial begin
        repeat (100000) @(posedge CLK_SYS);
        $display("mismatch at %0t: timeout", $time);
        failures++;
        stop_test();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {RSTN, WR, RD, SLEEP, TMR0_OVF, CMP1_OUT, CMP2_OUT} = 7'h00;
        CE = 1'b1;
        {ADDR, WDATA, GATE_IN, ext_run, xtal_run} = 21'h0;
        failures = 0;
        checks = 0;
        repeat (3) @(posedge CLK_SYS);
        RSTN <= 1'b1;
        repeat (3) @(posedge CLK_SYS);
        for (i = 0; i < 16; i++) begin
            rd(4'(i));
            cmp({8'h00, rd_v}, 16'h0000, 0);
        end
        foreach (rows[j]) begin
            wr(rows[j].a, rows[j].d, 1'b1);
            cmp({8'h00, rd_v}, {8'h00, rows[j].e}, 0);
        end
        for (s = 0; s < 2; s++) for (p = 0; p < 4; p++) begin
            runcnt(2'h0, {s ? gstmr_pkg::CS_INSTR : gstmr_pkg::CS_SYS, 2'(p), 4'h1}, 127);
            cmp({8'h00, rd_v}, 16'(128 / ((s ? gstmr_pkg::INSTR_DIV : 1) << p)), 1);
        end
        runcnt(2'h0, {gstmr_pkg::CS_LFOSC, 6'h01}, 1279);
        cmp({8'h00, rd_v}, 16'(1280 / gstmr_pkg::LFOSC_DIV), 1);
        for (s = 0; s < 4; s++) for (p = 0; p < 2; p++) for (g = 0; g < 2; g++) begin
            GATE_IN <= {3{g[0]}};
            {TMR0_OVF, CMP1_OUT, CMP2_OUT} <= {3{g[0]}};
            wr(ad(2'h1, gstmr_pkg::OFS_GCON), {1'b1, p[0], 4'h0, 2'(s)}, 1'b0);
            runcnt(2'h1, 8'h41, 31);
            cmp({8'h00, rd_v}, (g == p) ? 16'd32 : 16'd0, (g == p) ? 1 : 0);
        end
        wr(ad(2'h2, gstmr_pkg::OFS_CNT_HI), 8'hfc, 1'b0);
        wr(ad(2'h2, gstmr_pkg::OFS_CNT_LO), 8'h00, 1'b0);
        wr(ad(2'h2, gstmr_pkg::OFS_TCON), 8'h41, 1'b0);
        // Exactly 1024 increments from the preload
        repeat (1022) @(posedge CLK_SYS);
        wr(ad(2'h2, gstmr_pkg::OFS_TCON), 8'h00, 1'b0);
        rd(ad(2'h2, gstmr_pkg::OFS_CNT_HI));
        cmp({15'h0, OVF_IRQ[2]}, 16'h0001, 0);
        cmp({8'h00, rd_v}, 16'h0000, 0);
        wr(ad(2'h2, gstmr_pkg::OFS_GCON), 8'h00, 1'b1);
        cmp({8'h00, rd_v}, 16'h0000, 0);
        wr(ad(2'h0, gstmr_pkg::OFS_TCON), 8'h41, 1'b0);
        for (m = 0; m < 3; m++) begin
            c = (m == 2) ? 2'h2 : 2'h1;
            wr(ad(c, gstmr_pkg::OFS_CNT_LO), 8'h00, 1'b0);
            wr(ad(c, gstmr_pkg::OFS_TCON), (m == 0) ? 8'h81 : (m == 1) ? 8'h83 : 8'h85, 1'b0);
            SLEEP <= (m == 1);
            repeat (2) @(posedge CLK_SYS);
            rd(ad(2'h0, gstmr_pkg::OFS_CNT_LO));
            keep = rd_v;
            rises = 0;
            xo = 0;
            if (m == 2) xtal_run[2] <= 1'b1;
            else ext_run[1] <= 1'b1;
            repeat (120) @(posedge CLK_SYS);
            {ext_run, xtal_run} <= 6'h00;
            repeat (12) @(posedge CLK_SYS);
            rd(ad(2'h0, gstmr_pkg::OFS_CNT_LO));
            if (m == 1) cmp({8'h00, rd_v}, {8'h00, keep}, 0);
            SLEEP <= 1'b0;
            wr(ad(c, gstmr_pkg::OFS_TCON), 8'h00, 1'b0);
            rd(ad(c, gstmr_pkg::OFS_CNT_LO));
            cmp({8'h00, rd_v}, 16'(rises), 1);
            if (m == 2) cmp(16'(xo), 16'(rises), 0);
        end
        // Clock enable low for 20 cycles freezes the running count
        rd(ad(2'h0, gstmr_pkg::OFS_CNT_LO));
        keep = rd_v;
        @(posedge CLK_SYS);
        CE <= 1'b0;
        repeat (20) @(posedge CLK_SYS);
        CE <= 1'b1;
        rd(ad(2'h0, gstmr_pkg::OFS_CNT_LO));
        cmp({8'h00, rd_v}, {8'h00, 8'(keep + 8'h03)}, 0);
        RSTN <= 1'b0;
        repeat (2) @(posedge CLK_SYS);
        RSTN <= 1'b1;
        repeat (3) @(posedge CLK_SYS);
        rd(ad(2'h0, gstmr_pkg::OFS_TCON));
        cmp({8'h00, rd_v}, 16'h0000, 0);
        stop_test();
    end
endmodule : gstmr_tb
`default_nettype wire
